// ---- dv/tb_typec_port_data_mux_control.sv ----
/*
  Self-checking bench for the port mux control with its port model.
  Assumes a 200 MHz clock and one wait cycle on each register access.
*/
`timescale 1ns/1ps
module tb_typec_port_data_mux_control;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic orient_valid = 1'b0;
  logic orient_flip = 1'b0;
  logic [5:0] port_pin_i;
  tpm_pkg::tpm_pin_s [5:0] pin_ctl;
  logic [5:0] xpin_i = 6'h00;
  logic [5:0] xpin_o;
  logic [5:0] xpin_oe;
  logic endpoint_tx_en = 1'b0;
  logic endpoint_pos = 1'b0;
  logic endpoint_rx_pos;
  logic endpoint_rx_neg;
  logic endpoint_bit_tick;
  logic [1:0] endpoint_ls_pullup;
  logic [1:0] dplus_source_current;
  logic [1:0] dminus_pulldown;
  logic [11:0] detect_switch;
  logic cmp_irq;
  logic [5:0] cab_oe = 6'h00;
  logic [5:0] cab_val = 6'h00;
  logic [31:0] rd;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  // Short bit period keeps the tick check brief
  tpm_mux_ctrl #(.LS_BIT_CYC(4)) tpm_mux_ctrl_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .orient_valid(orient_valid),
    .orient_flip(orient_flip), .port_pin_i(port_pin_i),
    .pin_ctl(pin_ctl), .xpin_i(xpin_i), .xpin_o(xpin_o),
    .xpin_oe(xpin_oe), .endpoint_tx_en(endpoint_tx_en),
    .endpoint_pos(endpoint_pos), .endpoint_neg(~endpoint_pos),
    .endpoint_rx_pos(endpoint_rx_pos), .endpoint_rx_neg(endpoint_rx_neg),
    .endpoint_bit_tick(endpoint_bit_tick),
    .endpoint_ls_pullup(endpoint_ls_pullup),
    .dplus_source_current(dplus_source_current),
    .dminus_pulldown(dminus_pulldown), .detect_switch(detect_switch),
    .cmp_irq(cmp_irq));

  tpm_port_model tpm_port_model_inst (
    .sys_clk(sys_clk), .pin_ctl(pin_ctl), .cab_oe(cab_oe),
    .cab_val(cab_val), .port_pin_i(port_pin_i));

  task end_sim;
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // Generous ceiling; the whole run needs a few hundred cycles
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  // Comparator flag and irq are two registers deep
  task settle;
    repeat (5) @(posedge sys_clk);
  endtask : settle

  task orient(input logic v, input logic f);
    @(posedge sys_clk);
    orient_valid <= v;
    orient_flip <= f;
    settle();
  endtask : orient

  task t_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    chk({31'h0, |pin_ctl}, 32'h0);
    for (int a = 0; a < 24; a += 4)
    begin
      bus(1'b0, a[4:0], 32'h0, 4'hf);
      chk(rd, 32'h0);
    end
    for (int v = 0; v < 2; v++)
    begin
      xpin_i[0] <= v[0];
      settle();
      chk({xpin_oe[1], xpin_o[1]}, {1'b1, v[0]});
    end
  endtask : t_reset

  // Bypass output must hold while the enable is low
  task t_ce;
    ce <= 1'b0;
    xpin_i[0] <= 1'b0;
    settle();
    chk(xpin_o[1], 1'b1);
    ce <= 1'b1;
    settle();
    chk(xpin_o[1], 1'b0);
  endtask : t_ce

  task t_route;
    logic [2:0] cc;
    logic [2:0] s;
    bus(1'b1, tpm_pkg::OFS_ROUTE, 32'h007, 4'hf);
    bus(1'b1, 5'h1c, 32'hffffffff, 4'hf);
    bus(1'b0, 5'h1c, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'b0, tpm_pkg::OFS_ROUTE, 32'h0, 4'hf);
    chk(rd, 32'h007);
    orient(1'b0, 1'b0);
    chk({pin_ctl[0].sel, pin_ctl[0].clamp}, 4'h0);
    orient(1'b1, 1'b0);
    for (int c = 1; c < 8; c++)
    begin
      cc = c[2:0];
      s = (cc == 3'h2) ? 3'h0 : cc;
      bus(1'b1, tpm_pkg::OFS_ROUTE, {23'h0, cc, cc, cc}, 4'hf);
      settle();
      for (int i = 0; i < 6; i++)
      begin
        chk(pin_ctl[i].sel, (i < 4) ? cc : s);
        chk(pin_ctl[i].clamp, i < 4 || s != 3'h0);
      end
    end
    bus(1'b1, tpm_pkg::OFS_ROUTE, 32'h007, 4'hf);
    orient(1'b1, 1'b1);
    chk({pin_ctl[2].sel, pin_ctl[3].sel}, 6'h3f);
    chk({pin_ctl[0].sel, pin_ctl[0].clamp, pin_ctl[2].oe}, 5'h01);
    bus(1'b0, tpm_pkg::OFS_STATUS, 32'h0, 4'hf);
    chk(rd[5:3], 3'h3);
    bus(1'b1, tpm_pkg::OFS_ROUTE, 32'h1c7, 4'hf);
    settle();
    chk({pin_ctl[5].oe, pin_ctl[4].oe}, 2'h2);
    bus(1'b1, tpm_pkg::OFS_ROUTE, 32'h040, 4'hf);
    for (int f = 0; f < 2; f++)
      for (int v = 0; v < 2; v++)
      begin
        orient(1'b1, f[0]);
        xpin_i[3] <= v[0];
        settle();
        chk(pin_ctl[4 + f].o, v[0]);
      end
  endtask : t_route

  task t_ep;
    int n;
    bus(1'b1, tpm_pkg::OFS_ROUTE, 32'h202, 4'hf);
    bus(1'b1, tpm_pkg::OFS_DETECT, 32'h1, 4'hf);
    for (int f = 0; f < 2; f++)
    begin
      orient(1'b1, f[0]);
      chk(endpoint_ls_pullup, f ? 2'h2 : 2'h1);
      chk({dplus_source_current, dminus_pulldown}, f ? 4'ha : 4'h5);
    end
    cab_oe <= 6'h0c;
    cab_val <= 6'h08;
    settle();
    chk({endpoint_rx_pos, endpoint_rx_neg}, 2'h1);
    cab_oe <= 6'h00;
    endpoint_tx_en <= 1'b1;
    endpoint_pos <= 1'b1;
    settle();
    chk(endpoint_ls_pullup, 2'h0);
    chk({pin_ctl[2].o, pin_ctl[3].o}, 2'h2);
    endpoint_tx_en <= 1'b0;
    orient(1'b0, 1'b0);
    chk({endpoint_ls_pullup, dplus_source_current}, 4'h0);
    n = 0;
    while (endpoint_bit_tick !== 1'b1)
      @(posedge sys_clk);
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (endpoint_bit_tick !== 1'b1);
    chk(n, 4);
  endtask : t_ep

  task t_det;
    for (int k = 0; k < 12; k++)
    begin
      bus(1'b1, tpm_pkg::OFS_DETECT, 32'h2 << k, 4'hf);
      settle();
      chk(detect_switch, 12'h1 << k);
    end
    bus(1'b1, tpm_pkg::OFS_DETECT, 32'h1ffe, 4'h1);
    settle();
    chk(detect_switch, 12'h87f);
  endtask : t_det

  task t_pull;
    bus(1'b1, tpm_pkg::OFS_PULL, 32'ha95, 4'hf);
    settle();
    for (int i = 0; i < 6; i++)
      chk({pin_ctl[i].pu, pin_ctl[i].pd}, i[0] ? 2'h1 : 2'h2);
  endtask : t_pull

  task t_cmp;
    cab_oe <= 6'h01;
    bus(1'b1, tpm_pkg::OFS_CMPEN, 32'h0, 4'hf);
    cab_val[0] <= 1'b1;
    settle();
    chk(cmp_irq, 1'b0);
    bus(1'b1, tpm_pkg::OFS_CMPEN, 32'h1, 4'hf);
    cab_val[0] <= 1'b0;
    settle();
    chk(cmp_irq, 1'b1);
    bus(1'b0, tpm_pkg::OFS_CMPFLAG, 32'h0, 4'hf);
    chk(rd[5:0], 6'h01);
    bus(1'b1, tpm_pkg::OFS_CMPFLAG, 32'h1, 4'hf);
    settle();
    chk(cmp_irq, 1'b0);
    bus(1'b1, tpm_pkg::OFS_CMPEN, 32'h0, 4'hf);
  endtask : t_cmp

  task t_xbar;
    bus(1'b1, tpm_pkg::OFS_ROUTE, 32'h007, 4'hf);
    bus(1'b1, tpm_pkg::OFS_XBAR, 32'h1179, 4'hf);
    cab_oe <= 6'h02;
    orient(1'b1, 1'b0);
    for (int v = 0; v < 2; v++)
    begin
      xpin_i[0] <= v[0];
      cab_val[1] <= v[0];
      settle();
      chk(pin_ctl[0].o, v[0]);
      chk({xpin_oe[1], xpin_o[1]}, {1'b1, v[0]});
    end
    bus(1'b1, tpm_pkg::OFS_XBAR, 32'h079, 4'hf);
    settle();
    chk(xpin_oe[1], 1'b0);
    cab_oe <= 6'h00;
  endtask : t_xbar

  initial
  begin
    t_reset();
    t_ce();
    t_route();
    t_ep();
    t_det();
    t_pull();
    t_cmp();
    t_xbar();
    bus(1'b1, tpm_pkg::OFS_ROUTE, 32'h3ff, 4'hf);
    t_reset();
    end_sim();
  end
endmodule : tb_typec_port_data_mux_control

// ---- dv/tpm_port_model.sv ----
/*
  Receptacle and cable model on the port side of the mux control.
  Assumes pin_ctl from the mux control and cable drive set by the bench.
*/
`timescale 1ns/1ps
module tpm_port_model (
  input wire logic sys_clk,
  input tpm_pkg::tpm_pin_s [5:0] pin_ctl,
  input wire logic [5:0] cab_oe,
  input wire logic [5:0] cab_val,
  output logic [5:0] port_pin_i
);
  logic tog_q = 1'b0;

  always @(posedge sys_clk)
  begin
    tog_q <= ~tog_q;
  end

  // Floating pins wander so a stale level never passes for a drive
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (pin_ctl[i].oe)
        port_pin_i[i] = pin_ctl[i].o;
      else if (cab_oe[i])
        port_pin_i[i] = cab_val[i];
      else if (pin_ctl[i].pu)
        port_pin_i[i] = 1'b1;
      else if (pin_ctl[i].pd)
        port_pin_i[i] = 1'b0;
      else
        port_pin_i[i] = tog_q ^ i[0];
    end
  end
endmodule : tpm_port_model

// ---- hw/tpm_mux_ctrl.sv ----
/*
  Type-C port data multiplexer control: orientation routing, digital
  crossbar, pulls, clamps, comparator flags, endpoint pull-up and charger
  detection switches, with an Avalon-MM register slave.
  Assumes orientation and all pin inputs synchronous to sys_clk.
*/
// Chosen here: the register addresses and the Avalon-MM register port.
// Contract
// - Top and bottom D+/D- routing swaps with detected cable orientation.
// - Positive line goes to positive port pin, negative to negative.
// - Sideband pins swap signal pair when orientation is reversed.
// - Debug wire, debug lines, aux pair routable to top, bottom, sideband.
// - Sideband serial pair only to sideband pins, sys-to-port first.
// - Core serial 0 top, 1 bottom, 2 sideband; transmit first pin.
// - Crossbar maps serial, sideband serial, general pins to core channels.
// - Each crossbar pin individually set as input or output.
// - Before crossbar setup, serial transmit copies serial receive.
// - Enabled port comparators raise an interrupt on switching.
// - Separate pull-up and pull-down choices per port output.
// - Clamp engaged only while a second-stage path is closed.
// - Low-speed endpoint at 1.5 Mbps with control endpoint zero.
// - Endpoint pull-up disconnected while transmitting.
// - Receive-mode pull-up on top or bottom D- by orientation.
// - Contact detect source and pull-down on pins chosen by orientation.
// - Twelve independent charger detection switches under firmware.
// - Serial paths buffered with tri-state; sideband serial may pass analog.
`timescale 1ns/1ps
module tpm_mux_ctrl #(
  parameter int unsigned LS_BIT_CYC = tpm_pkg::LS_BIT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic orient_valid,
  input wire logic orient_flip,
  input wire logic [5:0] port_pin_i,
  output tpm_pkg::tpm_pin_s [5:0] pin_ctl,
  input wire logic [5:0] xpin_i,
  output logic [5:0] xpin_o,
  output logic [5:0] xpin_oe,
  input wire logic endpoint_tx_en,
  input wire logic endpoint_pos,
  input wire logic endpoint_neg,
  output logic endpoint_rx_pos,
  output logic endpoint_rx_neg,
  output logic endpoint_bit_tick,
  output logic [1:0] endpoint_ls_pullup,
  output logic [1:0] dplus_source_current,
  output logic [1:0] dminus_pulldown,
  output logic [11:0] detect_switch,
  output logic cmp_irq
);
  if (LS_BIT_CYC < 2 || LS_BIT_CYC > 255)
  begin : g_bad_rate
    $error("LS_BIT_CYC out of range");
  end

  logic [9:0] route_q;
  logic [13:0] xbar_q;
  logic [11:0] pull_q;
  logic [5:0] cmpen_q;
  logic [5:0] flag_q;
  logic [12:0] det_q;
  logic [5:0] pin_prev_q;
  logic [7:0] tick_cnt_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic acc_wr;
  tpm_pkg::tpm_pin_s [5:0] pin_d;
  logic [5:0] xo_d;
  logic [5:0] xoe_d;
  logic [2:0] ch_tx;
  logic [2:0] ch_rx;
  logic ep_rx_p_d;
  logic ep_rx_n_d;
  logic [5:0] cmp_set;

  // Write takes effect at the edge where waitrequest is seen low
  assign acc_wr = ce && avs_write && !wait_q;

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // One wait state per access keeps read data a clean flop output
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_read && wait_q)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      route_q <= tpm_pkg::ROUTE_RST;
      xbar_q <= tpm_pkg::XBAR_RST;
      pull_q <= tpm_pkg::PULL_RST;
      cmpen_q <= tpm_pkg::CMPEN_RST;
      det_q <= tpm_pkg::DET_RST;
    end
    else if (acc_wr)
    begin
      case (avs_address)
        tpm_pkg::OFS_ROUTE:
          route_q <= 10'(be_merge({22'h0, route_q}, avs_writedata,
            avs_byteenable));
        tpm_pkg::OFS_XBAR:
          xbar_q <= 14'(be_merge({18'h0, xbar_q}, avs_writedata,
            avs_byteenable));
        tpm_pkg::OFS_PULL:
          pull_q <= 12'(be_merge({20'h0, pull_q}, avs_writedata,
            avs_byteenable));
        tpm_pkg::OFS_CMPEN:
          cmpen_q <= 6'(be_merge({26'h0, cmpen_q}, avs_writedata,
            avs_byteenable));
        tpm_pkg::OFS_DETECT:
          det_q <= 13'(be_merge({19'h0, det_q}, avs_writedata,
            avs_byteenable));
        default:
          ;
      endcase
    end
  end

  always_comb
  begin
    case (avs_address)
      tpm_pkg::OFS_ROUTE: rdata_d = {22'h0, route_q};
      tpm_pkg::OFS_XBAR: rdata_d = {18'h0, xbar_q};
      tpm_pkg::OFS_PULL: rdata_d = {20'h0, pull_q};
      tpm_pkg::OFS_CMPEN: rdata_d = {26'h0, cmpen_q};
      tpm_pkg::OFS_CMPFLAG: rdata_d = {26'h0, flag_q};
      tpm_pkg::OFS_DETECT: rdata_d = {19'h0, det_q};
      tpm_pkg::OFS_STATUS:
        rdata_d = {26'h0, endpoint_tx_en, orient_flip, orient_valid,
          pin_prev_q[2:0]};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Comparators; analog pins must be disabled by firmware or they flag
  // on every slow ramp crossing
  assign cmp_set = cmpen_q & (port_pin_i ^ pin_prev_q);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_prev_q <= 6'h00;
      flag_q <= 6'h00;
      cmp_irq <= 1'b0;
    end
    else if (ce)
    begin
      pin_prev_q <= port_pin_i;
      // Set wins over a same-cycle write-one-to-clear
      if (acc_wr && avs_address == tpm_pkg::OFS_CMPFLAG && avs_byteenable[0])
      begin
        flag_q <= (flag_q & ~avs_writedata[5:0]) | cmp_set;
      end
      else
      begin
        flag_q <= flag_q | cmp_set;
      end
      cmp_irq <= |flag_q;
    end
  end

  // Routing, crossbar and pin control
  always_comb
  begin
    int fp;
    int sp;
    int ph;
    logic [2:0] s;
    logic [2:0] src;
    pin_d = '0;
    xo_d = 6'h00;
    xoe_d = 6'h00;
    ch_tx = 3'b111;
    ch_rx = 3'b111;
    ep_rx_p_d = 1'b1;
    ep_rx_n_d = 1'b0;
    fp = 0;
    sp = 0;
    ph = 0;
    s = 3'h0;
    src = 3'h0;
    if (xbar_q[tpm_pkg::XBAR_EN])
    begin
      for (int c = 0; c < 3; c++)
      begin
        src = {1'b0, xbar_q[tpm_pkg::XBAR_CH_LSB + 2*c +: 2]};
        if (src < 3'h3)
        begin
          ch_tx[c] = xpin_i[tpm_pkg::XB_TX_PINS[3*src +: 3]];
        end
      end
    end
    for (int c = 0; c < 3; c++)
    begin
      // Logical pair 0 or 1 moves to the opposite physical pair when flipped; pair 2 swaps its two pins
      ph = (c < 2) ? (c ^ int'(orient_flip)) : 2;
      fp = 2*ph + ((c == 2 && orient_flip) ? 1 : 0);
      sp = 2*ph + ((c == 2 && orient_flip) ? 0 : 1);
      s = orient_valid ? route_q[3*c +: 3] : 3'h0;
      if (c == 2 && (s == tpm_pkg::SRC_EP || s == tpm_pkg::SRC_ROOT))
      begin
        s = (s == tpm_pkg::SB_LSX) ? s : 3'h0;
      end
      pin_d[fp].sel = s;
      pin_d[sp].sel = s;
      if (s == tpm_pkg::SRC_CORE)
      begin
        pin_d[fp].o = ch_tx[c];
        pin_d[fp].oe = 1'b1;
        ch_rx[c] = port_pin_i[sp];
      end
      else if (c < 2 && s == tpm_pkg::SRC_EP)
      begin
        pin_d[fp].o = endpoint_pos;
        pin_d[sp].o = endpoint_neg;
        pin_d[fp].oe = endpoint_tx_en;
        pin_d[sp].oe = endpoint_tx_en;
        ep_rx_p_d = port_pin_i[fp];
        ep_rx_n_d = port_pin_i[sp];
      end
      else if (c == 2 && s == tpm_pkg::SB_LSX && !xbar_q[tpm_pkg::XBAR_ANALOG])
      begin
        // Buffered path; analog mode leaves only the switch closed
        pin_d[fp].o = xpin_i[tpm_pkg::XP_SB_S2P];
        pin_d[fp].oe = 1'b1;
        xo_d[tpm_pkg::XP_SB_P2S] = port_pin_i[sp];
        xoe_d[tpm_pkg::XP_SB_P2S] = 1'b1;
      end
    end
    for (int i = 0; i < 6; i++)
    begin
      pin_d[i].clamp = (pin_d[i].sel != 3'h0);
      pin_d[i].pu = pull_q[tpm_pkg::PULL_UP_LSB + i];
      pin_d[i].pd = pull_q[tpm_pkg::PULL_DN_LSB + i];
    end
    if (!xbar_q[tpm_pkg::XBAR_EN])
    begin
      xo_d[tpm_pkg::XP_SYS_TX] = xpin_i[0];
      xoe_d[tpm_pkg::XP_SYS_TX] = 1'b1;
    end
    else
    begin
      for (int c = 0; c < 3; c++)
      begin
        src = {1'b0, xbar_q[tpm_pkg::XBAR_CH_LSB + 2*c +: 2]};
        if (src < 3'h3)
        begin
          xo_d[tpm_pkg::XB_RX_PINS[3*src +: 3]] = ch_rx[c];
        end
      end
      // Pins set as outputs drive, as does the sideband port-to-sys pin while its buffered path is on
      xoe_d = xoe_d | xbar_q[tpm_pkg::XBAR_DIR_LSB +: 6];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pin_ctl <= '0;
      xpin_o <= 6'h00;
      xpin_oe <= 6'h00;
      endpoint_rx_pos <= 1'b1;
      endpoint_rx_neg <= 1'b0;
    end
    else if (ce)
    begin
      pin_ctl <= pin_d;
      xpin_o <= xo_d;
      xpin_oe <= xoe_d;
      endpoint_rx_pos <= ep_rx_p_d;
      endpoint_rx_neg <= ep_rx_n_d;
    end
  end

  // Endpoint bit strobe, orientation-dependent elements and detection switches
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tick_cnt_q <= 8'h00;
      endpoint_bit_tick <= 1'b0;
      endpoint_ls_pullup <= 2'b00;
      dplus_source_current <= 2'b00;
      dminus_pulldown <= 2'b00;
      detect_switch <= 12'h000;
    end
    else if (ce)
    begin
      endpoint_bit_tick <= (tick_cnt_q == 8'(LS_BIT_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 8'(LS_BIT_CYC - 1)) ? 8'h00
        : tick_cnt_q + 8'h01;
      endpoint_ls_pullup <= (orient_valid && route_q[tpm_pkg::ROUTE_EP_EN]
        && !endpoint_tx_en) ? {orient_flip, !orient_flip} : 2'b00;
      dplus_source_current <= (orient_valid && det_q[tpm_pkg::DET_DCD])
        ? {orient_flip, !orient_flip} : 2'b00;
      dminus_pulldown <= (orient_valid && det_q[tpm_pkg::DET_DCD])
        ? {orient_flip, !orient_flip} : 2'b00;
      detect_switch <= det_q[tpm_pkg::DET_SW_LSB +: tpm_pkg::DET_SW_NUM];
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  a_clamp_path: assert property (@(posedge sys_clk) disable iff (rst)
    ce && orient_valid && route_q[8:6] == tpm_pkg::SRC_CORE
    |=> pin_ctl[4].clamp && pin_ctl[5].clamp)
    else $error("clamp not tied to closed path");
  a_open_no_orient: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !orient_valid |=> pin_ctl[0].sel == 3'h0 && pin_ctl[5].sel == 3'h0
    && dplus_source_current == 2'b00)
    else $error("path closed without orientation");
  a_flip_top: assert property (@(posedge sys_clk) disable iff (rst)
    ce && orient_valid && orient_flip && route_q[2:0] == tpm_pkg::SRC_CORE
    |=> pin_ctl[2].oe && !pin_ctl[3].oe)
    else $error("top pair not moved on flip");
  a_sb_swap: assert property (@(posedge sys_clk) disable iff (rst)
    ce && orient_valid && orient_flip && route_q[8:6] == tpm_pkg::SRC_CORE
    |=> pin_ctl[5].oe && !pin_ctl[4].oe)
    else $error("sideband not swapped");
  a_pullup_tx: assert property (@(posedge sys_clk) disable iff (rst)
    ce && endpoint_tx_en |=> endpoint_ls_pullup == 2'b00)
    else $error("pull-up on during transmit");
  a_pullup_side: assert property (@(posedge sys_clk) disable iff (rst)
    ce && orient_valid && !orient_flip && route_q[9] && !endpoint_tx_en
    |=> endpoint_ls_pullup == 2'b01)
    else $error("pull-up on wrong side");
  a_dcd_side: assert property (@(posedge sys_clk) disable iff (rst)
    ce && orient_valid && orient_flip && det_q[0]
    |=> dplus_source_current == 2'b10 && dminus_pulldown == 2'b10)
    else $error("contact detect on wrong side");
  a_bypass_copy: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !xbar_q[0] |=> xpin_oe[1] && xpin_o[1] == $past(xpin_i[0]))
    else $error("serial bypass broken");
  a_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    ce && cmp_set[0] |=> flag_q[0] ##1 cmp_irq)
    else $error("comparator event lost");
  a_bit_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    ce && endpoint_bit_tick |=> !endpoint_bit_tick)
    else $error("bit strobe too close");
  a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
    ce && (avs_read || avs_write) && wait_q |=> !avs_waitrequest)
    else $error("bus answer late");

  c_flip_route: cover property (@(posedge sys_clk) disable iff (rst)
    orient_valid && orient_flip && pin_ctl[2].sel != 3'h0);
  c_irq: cover property (@(posedge sys_clk) disable iff (rst) cmp_irq);
  c_xbar_on: cover property (@(posedge sys_clk) disable iff (rst)
    xbar_q[0] && xpin_oe[5]);
endmodule : tpm_mux_ctrl

// ---- pkg/tpm_pkg.sv ----
/*
  Constants, register map and carrier types for the Type-C port data
  multiplexer control block. Assumes a 200 MHz core clock and a 32-bit
  Avalon-MM register bus with byte addresses.
*/
package tpm_pkg;
  // Core clock and endpoint bit rate
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned LS_RATE_KBPS = 1500;
  localparam int unsigned LS_BIT_CYC = CLK_KHZ / LS_RATE_KBPS;

  // Register byte offsets
  localparam logic [4:0] OFS_ROUTE = 5'h00;
  localparam logic [4:0] OFS_XBAR = 5'h04;
  localparam logic [4:0] OFS_PULL = 5'h08;
  localparam logic [4:0] OFS_CMPEN = 5'h0c;
  localparam logic [4:0] OFS_CMPFLAG = 5'h10;
  localparam logic [4:0] OFS_DETECT = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;

  // Field positions
  localparam int ROUTE_TOP_LSB = 0;
  localparam int ROUTE_BOT_LSB = 3;
  localparam int ROUTE_SB_LSB = 6;
  localparam int ROUTE_EP_EN = 9;
  localparam int XBAR_EN = 0;
  localparam int XBAR_CH_LSB = 1;
  localparam int XBAR_DIR_LSB = 7;
  localparam int XBAR_ANALOG = 13;
  localparam int PULL_UP_LSB = 0;
  localparam int PULL_DN_LSB = 6;
  localparam int DET_DCD = 0;
  localparam int DET_SW_LSB = 1;
  localparam int DET_SW_NUM = 12;

  // Reset values
  localparam logic [9:0] ROUTE_RST = 10'h000;
  localparam logic [13:0] XBAR_RST = 14'h0000;
  localparam logic [11:0] PULL_RST = 12'h000;
  localparam logic [5:0] CMPEN_RST = 6'h00;
  localparam logic [12:0] DET_RST = 13'h0000;

  // Crossbar pin pairs: tx source pin and rx sink pin per source code
  localparam logic [8:0] XB_TX_PINS = {3'h4, 3'h3, 3'h0};
  localparam logic [8:0] XB_RX_PINS = {3'h5, 3'h2, 3'h1};
  localparam int XP_SYS_TX = 1;
  localparam int XP_SB_P2S = 2;
  localparam int XP_SB_S2P = 3;

  // Sideband field code 1 selects the sideband serial pair
  localparam logic [2:0] SB_LSX = 3'h1;

  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_ROOT = 3'b001,
    SRC_EP = 3'b010,
    SRC_SWD = 3'b011,
    SRC_DBG12 = 3'b100,
    SRC_DBG34 = 3'b101,
    SRC_AUX = 3'b110,
    SRC_CORE = 3'b111
  } tpm_src_e;

  // Per port pin control; pins 0..5 are top pos/neg, bottom pos/neg,
  // sideband a/b
  typedef struct packed {
    logic [2:0] sel;
    logic o;
    logic oe;
    logic clamp;
    logic pu;
    logic pd;
  } tpm_pin_s;
endpackage : tpm_pkg
